// ---- core/bridge_protect.sv ----
// power stage protection and gate steering for three half bridges
// assumes link pins arrive asynchronously; sensor flags come from analog comparators
// Operation
// R01: two overcurrent modes picked by mode pins
// R02: per-cycle mode limits current, no shutdown
// R03: per-cycle second path latches bridge off
// R04: each bridge protected on its own
// R05: low-side trip blanks both until next cycle
// R06: high-side trip forces low side until cycle
// R07: latched mode trip shuts whole device down
// R08: controller pulses all resets after latch trip
// R09: highest trip level only in latched mode
// R10: warning low while above warning temperature
// R11: overtemperature hi-z all bridges, fault low
// R12: thermal latch cleared by all resets low
// R13: power-on holds device inactive, clears latches; code clears all but the thermal latch
// R14: undervoltage hi-z all bridges, fault low
// R15: undervoltage recovers by itself
// R16: reset low forces bridge hi-z
// R17: reset rise clears per-cycle bridge shutdown
// R18: global latches need rise on all resets
// R19: controller gives minimum low-side pulse each cycle
// R20: duty above half means positive current
// R21: two-quadrant use should pick latched mode
// R22: active-low fault and warning encoding
// R23: normal gate steering follows pwm
// R24: latched shutdowns ignore pwm activity
module bridge_protect (
  input  wire logic                          core_clk,
  input  wire logic                          rst,
  bridge_prot_if.device_end                  link,
  input  wire bridge_prot_pkg::phase_vec_t   high_side_oc,
  input  wire bridge_prot_pkg::phase_vec_t   low_side_oc,
  input  wire bridge_prot_pkg::phase_vec_t   short_detect,
  input  wire logic                          temp_warning,
  input  wire logic                          temp_shutdown,
  input  wire logic                          supply_undervoltage_guard,
  input  wire logic                          power_good,
  output logic [2:0]                         high_gate,
  output logic [2:0]                         low_gate
);
  logic [2:0] pwm_s1, pwm_s2;
  logic [2:0] rst_s1, rst_s2;
  logic [2:0] mode_s1, mode_s2;
  logic [2:0] pwm_prev, rst_prev;
  // comparator flags are asynchronous: two flops before any use
  logic [12:0] sense_s1, sense_s2;
  logic [2:0] hs_oc, ls_oc, short_oc;
  logic       warn_q, hot_q, uv_q, por_done;
  logic [2:0] blank_both, force_low, phase_latch, rise_seen;
  logic [2:0] next_blank_both, next_force_low, next_phase_latch, next_rise_seen;
  logic       thermal_shutdown_latch, oc_global_latch;
  logic       next_thermal_shutdown_latch, next_oc_global_latch;
  logic [2:0] next_high_gate, next_low_gate;
  logic       fault_q, next_fault;
  logic [2:0] rise, cycle_start;
  logic       latched_overcurrent_mode, any_oc, inactive;

  function automatic logic [2:0] rising(input logic [2:0] cur, input logic [2:0] prev);
    rising = cur & ~prev;
  endfunction

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pwm_s1 <= 3'h0;
      pwm_s2 <= 3'h0;
      rst_s1 <= 3'h7;
      rst_s2 <= 3'h7;
      mode_s1 <= 3'h0;
      mode_s2 <= 3'h0;
      pwm_prev <= 3'h0;
      rst_prev <= 3'h7;
      sense_s1 <= 13'h0000;
      sense_s2 <= 13'h0000;
    end
    else
    begin
      pwm_s1   <= link.pwm;
      pwm_s2   <= pwm_s1;
      rst_s1   <= link.phase_reset_n;
      rst_s2   <= rst_s1;
      mode_s1  <= {link.mode_select_2, link.mode_select_1, link.mode_select_0};
      mode_s2  <= mode_s1;
      pwm_prev <= pwm_s2;
      rst_prev <= rst_s2;
      sense_s1 <= {high_side_oc, low_side_oc, short_detect, temp_warning, temp_shutdown,
                   supply_undervoltage_guard, power_good};
      sense_s2 <= sense_s1;
    end
  end

  assign hs_oc    = sense_s2[12:10];
  assign ls_oc    = sense_s2[9:7];
  assign short_oc = sense_s2[6:4];
  assign warn_q   = sense_s2[3]; // R10
  assign hot_q    = sense_s2[2];
  assign uv_q     = sense_s2[1];
  assign por_done = sense_s2[0]; // R13

  // reset pins seed high so the release of rst gives no false rise
  assign rise = rising(rst_s2, rst_prev);
  assign cycle_start = rising(pwm_s2, pwm_prev);
  assign latched_overcurrent_mode = (mode_s2 == bridge_prot_pkg::mode_latched); // R01
  assign any_oc = |(hs_oc | ls_oc | short_oc);
  assign inactive = ~por_done | uv_q; // R13 R14 R15

  always_comb
  begin
    next_blank_both = blank_both;
    next_force_low = force_low;
    next_phase_latch = phase_latch;
    next_rise_seen = rise_seen | rise; // R18
    next_thermal_shutdown_latch = thermal_shutdown_latch | hot_q; // R11 R12
    next_oc_global_latch = oc_global_latch;
    if (latched_overcurrent_mode && any_oc)
      next_oc_global_latch = 1'b1; // R07
    for (int i = 0; i < 3; i++)
    begin
      if (cycle_start[i])
      begin
        next_blank_both[i] = 1'b0;
        next_force_low[i] = 1'b0;
      end
      if (rise[i])
        next_phase_latch[i] = 1'b0; // R17
      if (!latched_overcurrent_mode)
      begin
        if (ls_oc[i])
          next_blank_both[i] = 1'b1; // R02 R04 R05
        if (hs_oc[i])
          next_force_low[i] = 1'b1; // R06
        if (short_oc[i])
          next_phase_latch[i] = 1'b1; // R03
      end
    end
    // an active cause holds the latch: set wins over clear
    if (&next_rise_seen && !hot_q && !(latched_overcurrent_mode && any_oc))
    begin
      next_thermal_shutdown_latch = 1'b0; // R12 R18
      next_oc_global_latch = 1'b0;
      next_rise_seen = 3'h0;
    end
    if (!(thermal_shutdown_latch || oc_global_latch))
      next_rise_seen = 3'h0;
    if (!por_done)
    begin
      next_blank_both = 3'h0; // R13
      next_force_low = 3'h0;
      next_phase_latch = 3'h0;
      next_oc_global_latch = 1'b0;
    end
    next_fault = next_thermal_shutdown_latch | next_oc_global_latch | (|next_phase_latch)
      | inactive; // R22
    for (int i = 0; i < 3; i++)
    begin
      next_high_gate[i] = pwm_s2[i]; // R23
      next_low_gate[i] = ~pwm_s2[i];
      // forced low side first, hi-z below overrides it
      if (next_force_low[i])
      begin
        next_high_gate[i] = 1'b0;
        next_low_gate[i] = 1'b1;
      end
      if (next_blank_both[i] || next_phase_latch[i] || !rst_s2[i] || inactive
          || next_thermal_shutdown_latch || next_oc_global_latch)
      begin
        next_high_gate[i] = 1'b0; // R16 R24
        next_low_gate[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      blank_both <= 3'h0;
      force_low <= 3'h0;
      phase_latch <= 3'h0;
      rise_seen <= 3'h0;
      thermal_shutdown_latch <= 1'b0;
      oc_global_latch <= 1'b0;
      high_gate <= 3'h0;
      low_gate <= 3'h0;
      fault_q <= 1'b0;
    end
    else
    begin
      blank_both <= next_blank_both;
      force_low <= next_force_low;
      phase_latch <= next_phase_latch;
      rise_seen <= next_rise_seen;
      thermal_shutdown_latch <= next_thermal_shutdown_latch;
      oc_global_latch <= next_oc_global_latch;
      high_gate <= next_high_gate;
      low_gate <= next_low_gate;
      fault_q <= next_fault;
    end
  end

  // open drain: drive low only when asserted
  assign link.fault_n = 1'b0;
  assign link.fault_oe_n = ~fault_q; // R22
  assign link.overtemp_warning_n = 1'b0;
  assign link.overtemp_oe_n = ~warn_q; // R10
endmodule // bridge_protect

// ---- common/bridge_prot_pkg.sv ----
// constants and types shared by both ends of the bridge protection link
// assumes one core_clk domain with synchronous active-high reset
package bridge_prot_pkg;
  localparam int unsigned phase_count = 3;
  localparam logic [2:0] mode_per_cycle = 3'h0;
  localparam logic [2:0] mode_latched   = 3'h1;
  localparam int unsigned clk_period_ns = 10;
  localparam int unsigned low_pulse_min_ns = 100;
  localparam int unsigned low_pulse_cycles = (low_pulse_min_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int unsigned pwm_period_cycles = 200;
  localparam int unsigned pwm_half_cycles = pwm_period_cycles / 2;
  localparam logic [7:0] pwm_duty_reset = 8'h64;
  typedef logic [phase_count-1:0] phase_vec_t;
endpackage

// ---- common/bridge_prot_if.sv ----
// pin-level link between the controller and the power stage protection logic
// assumes open-drain status pins are resolved by the bench from the enables
interface bridge_prot_if;
  logic [2:0] pwm;
  logic [2:0] phase_reset_n;
  logic       mode_select_0;
  logic       mode_select_1;
  logic       mode_select_2;
  logic       fault_n;
  logic       fault_oe_n;
  logic       overtemp_warning_n;
  logic       overtemp_oe_n;

  modport device_end (
    input  pwm, phase_reset_n, mode_select_0, mode_select_1, mode_select_2,
    output fault_n, fault_oe_n, overtemp_warning_n, overtemp_oe_n
  );
  modport controller_end (
    output pwm, phase_reset_n, mode_select_0, mode_select_1, mode_select_2,
    input  fault_n, fault_oe_n, overtemp_warning_n, overtemp_oe_n
  );
endinterface

// ---- core/bridge_controller.sv ----
// controller end: one pwm shared by all three phases and fault recovery sequencing
// assumes status pins resolved by the bench from the open-drain enables
module bridge_controller (
  input  wire logic        core_clk,
  input  wire logic        rst,
  bridge_prot_if.controller_end link,
  input  wire logic [7:0]  duty,
  input  wire logic        use_latched_mode,
  input  wire logic [2:0]  phase_enable,
  input  wire logic        recover,
  output logic             fault_seen,
  output logic             warning_seen
);
  typedef enum logic [2:0] {
    st_run  = 3'b001,
    st_hold = 3'b010,
    st_rel  = 3'b100
  } rec_state_t;
  rec_state_t state, next_state;
  logic [7:0] count, next_count, duty_q, next_duty_q;
  logic [1:0] f_s, w_s;
  logic       next_fault_seen, next_warning_seen;
  logic [7:0] duty_max;

  assign duty_max = 8'(bridge_prot_pkg::pwm_period_cycles - bridge_prot_pkg::low_pulse_cycles);

  always_comb
  begin
    next_count = (count == 8'(bridge_prot_pkg::pwm_period_cycles - 1)) ? 8'h00 : count + 8'h01;
    next_duty_q = duty_q;
    if (next_count == 8'h00)
      next_duty_q = (duty > duty_max) ? duty_max : duty; // R19 R20
    next_state = state;
    unique case (state)
      st_run:  if (recover) next_state = st_hold; // R08 R12
      st_hold: if (next_count == 8'h00) next_state = st_rel;
      st_rel:  next_state = st_run;
    endcase
    next_fault_seen = ~f_s[1];
    next_warning_seen = ~w_s[1];
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state <= st_run;
      count <= 8'h00;
      duty_q <= bridge_prot_pkg::pwm_duty_reset;
      f_s <= 2'h3;
      w_s <= 2'h3;
      fault_seen <= 1'b0;
      warning_seen <= 1'b0;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
      duty_q <= next_duty_q;
      f_s <= {f_s[0], link.fault_n | link.fault_oe_n};
      w_s <= {w_s[0], link.overtemp_warning_n | link.overtemp_oe_n};
      fault_seen <= next_fault_seen;
      warning_seen <= next_warning_seen;
    end
  end

  assign link.pwm = (count < duty_q) ? 3'h7 : 3'h0;
  assign link.phase_reset_n = (state == st_hold) ? 3'h0 : phase_enable; // R08 R12
  assign link.mode_select_0 = use_latched_mode; // R09 R21
  assign link.mode_select_1 = 1'b0;
  assign link.mode_select_2 = 1'b0;
endmodule // bridge_controller

// ---- test/bridge_prot_props.sv ----
// checker for the link pins and the device end outputs
// assumes one core_clk domain, sync reset, enables low while pulling a pin
module bridge_prot_props (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic [2:0] phase_reset_n,
  input wire logic       mode_select_0,
  input wire logic       fault_oe_n,
  input wire logic       overtemp_oe_n,
  input wire logic [2:0] high_side_oc,
  input wire logic [2:0] low_side_oc,
  input wire logic       temp_warning,
  input wire logic       temp_shutdown,
  input wire logic       supply_undervoltage_guard,
  input wire logic       power_good,
  input wire logic [2:0] high_gate,
  input wire logic [2:0] low_gate
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // sensor flags pass two sync flops and the gate register: three cycles
  property p_rst_hiz;
    (~$past(phase_reset_n, 3) & ~$past(phase_reset_n, 4) & (high_gate | low_gate)) == 3'h0;
  endproperty
  a_rst_hiz: assert property (p_rst_hiz) else $error("gates on in phase reset");
  property p_uv_off;
    supply_undervoltage_guard |-> ##3 (high_gate | low_gate) == 3'h0;
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("gates on in undervoltage");
  property p_uv_fault;
    supply_undervoltage_guard [*3] |=> !fault_oe_n;
  endproperty
  a_uv_fault: assert property (p_uv_fault) else $error("fault idle in undervoltage");
  property p_hot_off;
    temp_shutdown |-> ##3 (high_gate | low_gate) == 3'h0;
  endproperty
  a_hot_off: assert property (p_hot_off) else $error("gates on when hot");
  property p_warn;
    temp_warning [*3] |-> !overtemp_oe_n;
  endproperty
  a_warn: assert property (p_warn) else $error("warning not driven");
  property p_por;
    !power_good |-> ##3 (high_gate | low_gate) == 3'h0;
  endproperty
  a_por: assert property (p_por) else $error("gates on before power good");
  property p_hs_trip;
    |high_side_oc |-> ##3 (high_gate & $past(high_side_oc, 3)) == 3'h0;
  endproperty
  a_hs_trip: assert property (p_hs_trip) else $error("high side on after trip");
  property p_ls_trip;
    !mode_select_0 && |low_side_oc
      |-> ##3 ((high_gate | low_gate) & $past(low_side_oc, 3)) == 3'h0;
  endproperty
  a_ls_trip: assert property (p_ls_trip) else $error("bridge on after low trip");
endmodule // bridge_prot_props

// ---- test/three_phase_bridge_protection_test.sv ----
// bench joining controller and device ends on one link
// assumes 100 MHz core_clk, sync active-high rst, pull-ups on status pins
module three_phase_bridge_protection_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk = 1'b0;
  logic       rst = 1'b1;
  logic [2:0] high_side_oc = 3'h0, low_side_oc = 3'h0, short_detect = 3'h0;
  logic       temp_warning = 1'b0, temp_shutdown = 1'b0, uv = 1'b0, power_good = 1'b1;
  logic [7:0] duty = 8'h64;
  logic       latched = 1'b0, recover = 1'b0;
  logic [2:0] phase_enable = 3'h7, high_gate, low_gate;
  logic       fault_seen, warning_seen;
  int         num_errors = 0, samples_checked = 0;
  bridge_prot_if link ();
  wire        fault_line = link.fault_n | link.fault_oe_n;
  wire        warn_line = link.overtemp_warning_n | link.overtemp_oe_n;
  always #5 core_clk = ~core_clk;
  bridge_protect bridge_protect_i (.core_clk, .rst, .link(link.device_end), .high_side_oc,
    .low_side_oc, .short_detect, .temp_warning, .temp_shutdown,
    .supply_undervoltage_guard(uv), .power_good, .high_gate, .low_gate);
  bridge_controller bridge_controller_i (.core_clk, .rst, .link(link.controller_end), .duty,
    .use_latched_mode(latched), .phase_enable, .recover, .fault_seen, .warning_seen);
  bridge_prot_props bridge_prot_props_i (.core_clk, .rst, .phase_reset_n(link.phase_reset_n),
    .mode_select_0(link.mode_select_0), .fault_oe_n(link.fault_oe_n),
    .overtemp_oe_n(link.overtemp_oe_n), .high_side_oc, .low_side_oc, .temp_warning,
    .temp_shutdown, .supply_undervoltage_guard(uv), .power_good, .high_gate, .low_gate);
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic gates(input logic [5:0] e);
    cmp({2'h0, high_gate, low_gate}, {2'h0, e});
  endtask
  task automatic pins(input logic [1:0] e);
    cmp({6'h0, fault_line, warn_line}, {6'h0, e});
  endtask
  // controller's view of the status pins, as line levels
  task automatic seen(input logic [1:0] e);
    cmp({6'h0, ~fault_seen, ~warning_seen}, {6'h0, e});
  endtask
  task automatic complete_run;
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wait_for(input bit f, input logic lvl);
    int n;
    n = 0;
    while ((f ? fault_line : link.pwm[0]) !== lvl && n < 400)
    begin
      step(1);
      n++;
    end
    if (n == 400)
    begin
      num_errors++;
      complete_run();
    end
  endtask
  // sync to a fresh pwm high period
  task automatic rise;
    wait_for(0, 1'b0);
    wait_for(0, 1'b1);
    step(5);
  endtask
  task automatic pulse(ref logic [2:0] s, input logic [2:0] v);
    s = v;
    step(1);
    s = 3'h0;
    step(2);
  endtask
  task automatic revive;
    recover = 1'b1;
    step(1);
    recover = 1'b0;
    wait_for(1, 1'b1);
    step(4);
  endtask
  // cycles of one pwm high period against the expected count
  task automatic measure(input logic [7:0] exp);
    int n;
    n = 0;
    wait_for(0, 1'b0);
    wait_for(0, 1'b1);
    while (link.pwm[0] === 1'b1 && n < 300)
    begin
      step(1);
      n++;
    end
    if (n == 300)
    begin
      num_errors++;
      complete_run();
    end
    cmp(8'(n), exp);
  endtask
  initial
  begin
    step(16);
    rst = 1'b0;
    rise();
    gates(6'h38);
    pins(2'h3);
    seen(2'h3);
    wait_for(0, 1'b0);
    step(5);
    pulse(low_side_oc, 3'h2);
    gates(6'h05);
    rise();
    gates(6'h38);
    pulse(high_side_oc, 3'h1);
    gates(6'h31);
    rise();
    gates(6'h38);
    pulse(short_detect, 3'h4);
    gates(6'h18);
    pins(2'h1);
    phase_enable = 3'h1;
    step(8);
    gates(6'h08);
    seen(2'h1);
    phase_enable = 3'h7;
    step(8);
    pins(2'h3);
    gates(6'h38);
    $display("test cycle limiting done");
    temp_warning = 1'b1;
    step(4);
    pins(2'h2);
    temp_warning = 1'b0;
    temp_shutdown = 1'b1;
    step(4);
    temp_shutdown = 1'b0;
    gates(6'h00);
    pins(2'h1);
    phase_enable = 3'h6;
    step(8);
    phase_enable = 3'h7;
    step(8);
    pins(2'h1);
    gates(6'h00);
    seen(2'h1);
    revive();
    pins(2'h3);
    seen(2'h3);
    $display("test thermal done");
    uv = 1'b1;
    step(4);
    gates(6'h00);
    pins(2'h1);
    uv = 1'b0;
    step(8);
    pins(2'h3);
    power_good = 1'b0;
    step(3);
    gates(6'h00);
    power_good = 1'b1;
    $display("test supply done");
    latched = 1'b1;
    rise();
    pulse(high_side_oc, 3'h2);
    gates(6'h00);
    pins(2'h1);
    step(20);
    pins(2'h1);
    revive();
    pins(2'h3);
    $display("test latched done");
    measure(8'(bridge_prot_pkg::pwm_half_cycles));
    duty = 8'hff;
    measure(8'(bridge_prot_pkg::pwm_period_cycles - bridge_prot_pkg::low_pulse_cycles));
    $display("test duty done");
    complete_run();
  end
endmodule // three_phase_bridge_protection_test
